// ===== common/hpcf_pkg.sv
package hpcf_pkg;

   // Change word layout.
   localparam int CHG_WIDTH   = 16;
   localparam int NUM_FLAGS   = 5;
   localparam int BIT_CONNECT = 0;
   localparam int BIT_ENABLE  = 1;
   localparam int BIT_SUSPEND = 2;
   localparam int BIT_OVERCUR = 3;
   localparam int BIT_RESET   = 4;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h00;

   // Flag selector carried by a feature request: the selector is the bit position.
   localparam int SEL_WIDTH = 4;

   // Port states, one-hot.
   typedef enum logic [11:0]
   {
      PS_POWERED_OFF   = 12'h001,
      PS_NOT_CONFIG    = 12'h002,
      PS_DISCONNECTED  = 12'h004,
      PS_DISABLED      = 12'h008,
      PS_RESETTING     = 12'h010,
      PS_SPEED_EVAL    = 12'h020,
      PS_ENABLED       = 12'h040,
      PS_TRANSMIT      = 12'h080,
      PS_SUSPENDED     = 12'h100,
      PS_RESUMING      = 12'h200,
      PS_SEND_EOP      = 12'h400,
      PS_RESTART_S     = 12'h800
   } hpcf_port_state_t;

endpackage

// ===== logic/hpcf_status_track.sv
`timescale 1ns/1ps
module hpcf_status_track
(
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   input  hpcf_pkg::hpcf_port_state_t     portState,
   input  wire logic                      connectStatus,
   input  wire logic                      enableStatus,
   input  wire logic                      overCurrentStatus,
   output hpcf_pkg::hpcf_port_state_t     prevState,
   output logic                           prevConnect,
   output logic                           prevEnable,
   output logic                           prevOverCurrent
);
   import hpcf_pkg::*;

   typedef struct packed
   {
      hpcf_port_state_t state;
      logic             conn;
      logic             ena;
      logic             oc;
   } hpcf_track_t;

   hpcf_track_t trk_q;
   hpcf_track_t trk_d;

   ////////////////////////////////////////////////////////////////////////////
   // The previous cycle's port state and status, used for edge detection.
   always_comb
   begin
      trk_d.state = portState;
      trk_d.conn  = connectStatus;
      trk_d.ena   = enableStatus;
      trk_d.oc    = overCurrentStatus;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         trk_q <= '{state: PS_POWERED_OFF, conn: 1'b0, ena: 1'b0, oc: 1'b0};
      end
      else
      begin
         trk_q <= trk_d;
      end
   end

   assign prevState       = trk_q.state;
   assign prevConnect     = trk_q.conn;
   assign prevEnable      = trk_q.ena;
   assign prevOverCurrent = trk_q.oc;

endmodule

// ===== logic/hpcf_change_flags.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - Only port events set change flags; R03 set requests also set them here
// R02 - Clear request or hub reset clears flags
// R03 - Set request forces flag, else error/no-op
// R04 - Attach/detach connect change sets bit 0
// R05 - Connect flag cleared; zero while powered off
// R06 - Enable flag only on error disable; R07 invalid idle also sets it here
// R07 - Reset into invalid idle may set enable
// R08 - Resume-complete transitions set suspend flag
// R09 - Suspend flag waits until resume signaling stops
// R10 - Enable/suspend/reset flags zero while powered off
// R11 - Over-current toggle sets bit 3
// R12 - Power-off by other port's over-current sets
// R13 - Over-current flag cleared when not configured
// R14 - No per-port over-current: bit 3 zero
// R15 - Resetting/speed-eval to enabled sets bit 4
// R16 - Bits 5 to 15 read zero
// R17 - Flags sticky; clear touches named flag only
module hpcf_change_flags
#(
   parameter bit DIAG_SET_EN      = 1'b1,
   parameter bit SET_REFUSE_ERROR = 1'b1,
   parameter bit PER_PORT_OC      = 1'b1,
   parameter bit RESET_IDLE_FLAG  = 1'b1
)
(
   input  wire logic                           ref_clk,
   input  wire logic                           nrst,
   input  wire logic                           hubReset,
   input  hpcf_pkg::hpcf_port_state_t          portState,
   input  wire logic                           connectStatus,
   input  wire logic                           attachDetachEvent,
   input  wire logic                           enableStatus,
   input  wire logic                           portErrorEvent,
   input  wire logic                           resetIdleFail,
   input  wire logic                           resumeDriving,
   input  wire logic                           overCurrentStatus,
   input  wire logic                           otherPortOcPowerOff,
   input  wire logic                           reqValid,
   input  wire logic                           reqSet,
   input  wire logic [hpcf_pkg::SEL_WIDTH-1:0] reqSel,
   output logic                                reqAck,
   output logic                                reqError,
   output logic [hpcf_pkg::CHG_WIDTH-1:0]      portChangeFlags
);
   import hpcf_pkg::*;

   // Refuse a package layout whose flags do not fit the word or the selector.
   if (NUM_FLAGS > CHG_WIDTH || (1 << SEL_WIDTH) < NUM_FLAGS)
   begin
      $error("Change word cannot hold the flags.");
   end

   typedef struct packed
   {
      logic [NUM_FLAGS-1:0] flags;
      logic                 suspPend;
      logic                 ack;
      logic                 err;
   } hpcf_state_t;

   hpcf_state_t      st_q;
   hpcf_state_t      st_d;
   hpcf_port_state_t prevState;
   logic             prevConnect;
   logic             prevEnable;
   logic             prevOverCurrent;

   hpcf_status_track u_track
   (
      .ref_clk           (ref_clk),
      .nrst              (nrst),
      .portState         (portState),
      .connectStatus     (connectStatus),
      .enableStatus      (enableStatus),
      .overCurrentStatus (overCurrentStatus),
      .prevState         (prevState),
      .prevConnect       (prevConnect),
      .prevEnable        (prevEnable),
      .prevOverCurrent   (prevOverCurrent)
   );

   // One-hot mask of the flag named by a request; out-of-range selectors give zero.
   function automatic logic [NUM_FLAGS-1:0] sel_mask(input logic [SEL_WIDTH-1:0] sel);
      logic [NUM_FLAGS-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_FLAGS; i++)
      begin
         if (sel == SEL_WIDTH'(i))
         begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Flag update.
   always_comb
   begin
      logic [NUM_FLAGS-1:0] ev;
      logic [NUM_FLAGS-1:0] clr;
      logic [NUM_FLAGS-1:0] force_set;
      logic [NUM_FLAGS-1:0] mask;
      logic                 suspTrans;
      logic                 suspWait;
      ev        = '0;
      clr       = '0;
      force_set = '0;
      suspTrans = 1'b0;
      suspWait  = 1'b0;
      mask      = sel_mask(reqSel);
      st_d      = st_q;
      st_d.ack  = 1'b0;
      st_d.err  = 1'b0;

      // R01 events only
      // R04 connect change
      ev[BIT_CONNECT] = attachDetachEvent && (connectStatus != prevConnect);
      // R06 error disable
      ev[BIT_ENABLE]  = portErrorEvent && prevEnable && !enableStatus;
      // R07 invalid idle
      if (RESET_IDLE_FLAG && resetIdleFail)
      begin
         ev[BIT_ENABLE] = 1'b1;
      end

      // R08 resume complete
      suspTrans = ((prevState == PS_RESUMING) && (portState == PS_SEND_EOP)) ||
                  ((prevState == PS_RESTART_S) && (portState == PS_TRANSMIT));
      suspWait  = st_q.suspPend || suspTrans;
      // R09 after resume stops
      ev[BIT_SUSPEND] = suspWait && !resumeDriving;
      st_d.suspPend   = suspWait && resumeDriving;

      // R11 over-current toggle
      ev[BIT_OVERCUR] = (overCurrentStatus != prevOverCurrent);
      // R12 other-port power-off
      if (otherPortOcPowerOff)
      begin
         ev[BIT_OVERCUR] = 1'b1;
      end

      // R15 reset complete
      ev[BIT_RESET] = ((prevState == PS_RESETTING) || (prevState == PS_SPEED_EVAL)) &&
                      (portState == PS_ENABLED);

      if (reqValid)
      begin
         if (mask == '0)
         begin
            st_d.err = 1'b1;
         end
         else if (!reqSet)
         begin
            // R02 clear request
            clr      = mask;
            st_d.ack = 1'b1;
         end
         // R03 diagnostic set
         else if (DIAG_SET_EN)
         begin
            force_set = mask;
            st_d.ack  = 1'b1;
         end
         else if (SET_REFUSE_ERROR)
         begin
            st_d.err = 1'b1;
         end
         else
         begin
            st_d.ack = 1'b1;
         end
      end

      // R17 sticky, set wins
      st_d.flags = (st_q.flags & ~clr) | ev | force_set;

      if (portState == PS_POWERED_OFF)
      begin
         // R05 connect held zero
         st_d.flags[BIT_CONNECT] = 1'b0;
         // R10 held zero
         st_d.flags[BIT_ENABLE]  = 1'b0;
         st_d.flags[BIT_SUSPEND] = 1'b0;
         st_d.flags[BIT_RESET]   = 1'b0;
         st_d.suspPend           = 1'b0;
      end

      // R13 not configured
      if (portState == PS_NOT_CONFIG)
      begin
         st_d.flags[BIT_OVERCUR] = 1'b0;
      end

      // R14 no per-port report
      if (!PER_PORT_OC)
      begin
         st_d.flags[BIT_OVERCUR] = 1'b0;
      end

      // R02 hub reset
      if (hubReset)
      begin
         st_d.flags    = FLAGS_RESET;
         st_d.suspPend = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         st_q <= '{flags: FLAGS_RESET, suspPend: 1'b0, ack: 1'b0, err: 1'b0};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign reqAck   = st_q.ack;
   assign reqError = st_q.err;
   // R16 reserved zero
   assign portChangeFlags = {{(CHG_WIDTH-NUM_FLAGS){1'b0}}, st_q.flags};

endmodule

// ===== dv/hpcf_host_model.sv
`timescale 1ns/1ps
module hpcf_host_model
(
   input  wire logic                           ref_clk,
   output logic                                reqValid,
   output logic                                reqSet,
   output logic [hpcf_pkg::SEL_WIDTH-1:0]      reqSel,
   input  wire logic                           reqAck,
   input  wire logic                           reqError
);
   import hpcf_pkg::*;

   initial
   begin
      reqValid = 1'b0;
      reqSet   = 1'b0;
      reqSel   = '0;
   end

   // Called at a falling edge; released lines show the inverse so stale values never pass.
   task automatic req(input logic s, input logic [SEL_WIDTH-1:0] sel, output logic [1:0] rsp);
      reqValid = 1'b1;
      reqSet   = s;
      reqSel   = sel;
      @(negedge ref_clk);
      rsp      = {reqAck, reqError};
      reqValid = 1'b0;
      reqSet   = ~s;
      reqSel   = ~sel;
   endtask
endmodule

// ===== dv/hpcf_change_flags_checker.sv
`timescale 1ns/1ps
module hpcf_change_flags_checker
(
   input  wire logic                           ref_clk,
   input  wire logic                           nrst,
   input  wire logic                           hubReset,
   input  hpcf_pkg::hpcf_port_state_t          portState,
   input  wire logic                           portErrorEvent,
   input  wire logic                           resetIdleFail,
   input  wire logic                           resumeDriving,
   input  wire logic                           overCurrentStatus,
   input  wire logic                           reqValid,
   input  wire logic                           reqSet,
   input  wire logic [hpcf_pkg::SEL_WIDTH-1:0] reqSel,
   input  wire logic                           reqAck,
   input  wire logic                           reqError,
   input  wire logic [hpcf_pkg::CHG_WIDTH-1:0] portChangeFlags
);
   import hpcf_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_rsv; portChangeFlags[15:5] == 11'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_rsp; reqValid |=> (reqAck ^ reqError) && (reqError == ($past(reqSel) > 4'h4)); endproperty
   a_rsp: assert property (p_rsp) else $error("bad request answer");
   property p_hub; hubReset |=> portChangeFlags == 16'h0; endproperty
   a_hub: assert property (p_hub) else $error("hub reset left flags");
   property p_off; portState == PS_POWERED_OFF |=> (portChangeFlags & 16'h0017) == 16'h0; endproperty
   a_off: assert property (p_off) else $error("flags set while powered off");
   property p_oc; $past(nrst) && $changed(overCurrentStatus) && !hubReset && portState != PS_NOT_CONFIG |=> portChangeFlags[3]; endproperty
   a_oc: assert property (p_oc) else $error("over-current toggle missed");
   property p_keep;
      portChangeFlags[0] && !hubReset && portState != PS_POWERED_OFF && !(reqValid && !reqSet && reqSel == 4'h0)
      |=> portChangeFlags[0];
   endproperty
   a_keep: assert property (p_keep) else $error("connect flag lost");
   property p_sus; $rose(portChangeFlags[2]) && !$past(reqValid) |-> !$past(resumeDriving); endproperty
   a_sus: assert property (p_sus) else $error("suspend flag during resume");
   property p_en; !reqValid && !resetIdleFail && !portErrorEvent && !portChangeFlags[1] |=> !portChangeFlags[1]; endproperty
   a_en: assert property (p_en) else $error("enable flag without error");
endmodule

bind hpcf_change_flags hpcf_change_flags_checker chk_i (.ref_clk, .nrst, .hubReset, .portState, .portErrorEvent,
   .resetIdleFail, .resumeDriving, .overCurrentStatus, .reqValid, .reqSet, .reqSel, .reqAck, .reqError,
   .portChangeFlags);

// ===== dv/hpcf_tb.sv
`timescale 1ns/1ps
module tb;
   import hpcf_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, hubReset = 1'b0, connectStatus = 1'b0, attachDetachEvent = 1'b0;
   logic enableStatus = 1'b0, portErrorEvent = 1'b0, resetIdleFail = 1'b0, resumeDriving = 1'b0;
   logic overCurrentStatus = 1'b0, otherPortOcPowerOff = 1'b0, reqValid, reqSet, reqAck, reqError;
   hpcf_port_state_t portState = PS_DISCONNECTED;
   logic [SEL_WIDTH-1:0] reqSel;
   logic [CHG_WIDTH-1:0] portChangeFlags;
   logic [1:0] rsp;
   int fails = 0, n_checks = 0;

   always #2 ref_clk = ~ref_clk;

   hpcf_change_flags uut (.ref_clk, .nrst, .hubReset, .portState, .connectStatus, .attachDetachEvent,
      .enableStatus, .portErrorEvent, .resetIdleFail, .resumeDriving, .overCurrentStatus,
      .otherPortOcPowerOff, .reqValid, .reqSet, .reqSel, .reqAck, .reqError, .portChangeFlags);
   hpcf_host_model host (.ref_clk, .reqValid, .reqSet, .reqSel, .reqAck, .reqError);

   ////////////////////////////////////////////////////////////////////////////
   // One cycle on; event pulses last exactly one cycle.
   task step();
      @(negedge ref_clk);
      {attachDetachEvent, portErrorEvent, resetIdleFail, otherPortOcPowerOff, hubReset} = '0;
   endtask
   task chk(input logic [4:0] e);
      n_checks++;
      if (portChangeFlags !== {11'h0, e})
      begin
         fails++;
         $display("ERROR %0t flags %h exp %h", $time, portChangeFlags, e);
      end
   endtask
   task chkr(input logic [1:0] e);
      n_checks++;
      if (rsp !== e)
      begin
         fails++;
         $display("ERROR %0t answer %b exp %b", $time, rsp, e);
      end
   endtask
   task hreq(input logic s, input logic [SEL_WIDTH-1:0] sel, input logic [1:0] e);
      host.req(s, sel, rsp);
      chkr(e);
      step();
   endtask
   task close_out();
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      step();
      chk(5'h00);
      connectStatus = 1'b1;
      attachDetachEvent = 1'b1;
      step();
      chk(5'h01);
      hreq(1'b0, 4'h0, 2'b10);
      chk(5'h00);
      connectStatus = 1'b0;
      step();
      chk(5'h00);
      enableStatus = 1'b1;
      step();
      enableStatus = 1'b0;
      step();
      chk(5'h00);
      enableStatus = 1'b1;
      step();
      enableStatus = 1'b0;
      portErrorEvent = 1'b1;
      step();
      chk(5'h02);
      hreq(1'b0, 4'h1, 2'b10);
      chk(5'h00);
      resetIdleFail = 1'b1;
      step();
      chk(5'h02);
      portState = PS_RESUMING;
      resumeDriving = 1'b1;
      step();
      portState = PS_SEND_EOP;
      step();
      step();
      chk(5'h02);
      resumeDriving = 1'b0;
      step();
      chk(5'h06);
      hreq(1'b0, 4'h2, 2'b10);
      chk(5'h02);
      portState = PS_RESTART_S;
      step();
      portState = PS_TRANSMIT;
      step();
      chk(5'h06);
      overCurrentStatus = 1'b1;
      step();
      chk(5'h0e);
      hreq(1'b0, 4'h3, 2'b10);
      overCurrentStatus = 1'b0;
      step();
      chk(5'h0e);
      hreq(1'b0, 4'h3, 2'b10);
      otherPortOcPowerOff = 1'b1;
      step();
      chk(5'h0e);
      // A toggle in the same cycle as the clear keeps the flag set.
      overCurrentStatus = 1'b1;
      hreq(1'b0, 4'h3, 2'b10);
      chk(5'h0e);
      portState = PS_RESETTING;
      step();
      portState = PS_ENABLED;
      step();
      chk(5'h1e);
      hreq(1'b0, 4'h4, 2'b10);
      portState = PS_SPEED_EVAL;
      step();
      portState = PS_ENABLED;
      step();
      chk(5'h1e);
      hreq(1'b0, 4'h4, 2'b10);
      hreq(1'b1, 4'h4, 2'b10);
      chk(5'h1e);
      hreq(1'b1, 4'h5, 2'b01);
      hreq(1'b0, 4'hf, 2'b01);
      chk(5'h1e);
      portState = PS_POWERED_OFF;
      step();
      chk(5'h08);
      hreq(1'b1, 4'h0, 2'b10);
      chk(5'h08);
      portState = PS_NOT_CONFIG;
      step();
      chk(5'h00);
      portState = PS_DISCONNECTED;
      hreq(1'b1, 4'h0, 2'b10);
      chk(5'h01);
      // Hub reset beats an over-current toggle in the same cycle.
      overCurrentStatus = 1'b0;
      hubReset = 1'b1;
      step();
      chk(5'h00);
      step();
      chk(5'h00);
      close_out();
   end
endmodule
